// ==== core/rcbl_params.svh ====
// Constants of the reset controller with boot latch
`ifndef RCBL_PARAMS_SVH
`define RCBL_PARAMS_SVH

// Register offsets
`define RCBL_OFS_CAUSE 8'h00
`define RCBL_OFS_CTRL 8'h04

// Cause register fields
`define RCBL_CAUSE_POR 0
`define RCBL_CAUSE_LVI 1
`define RCBL_CAUSE_EXT 2
`define RCBL_CAUSE_LOL 3
`define RCBL_CAUSE_LOC 4
`define RCBL_CAUSE_WDT 5
`define RCBL_CAUSE_CHK 6
`define RCBL_CAUSE_SW 7
`define RCBL_CAUSE_BOOT 16
`define RCBL_CAUSE_RST 8'h01
`define RCBL_CAUSE_EXTONLY 8'h04

// Control register fields
`define RCBL_CTRL_SW 0
`define RCBL_CTRL_LOLE 1
`define RCBL_CTRL_CLKRC 2

// Boot-select encodings
`define RCBL_BOOT_FLASH 1'h0
`define RCBL_BOOT_SERIAL 1'h1

// Timing counts in clock cycles
`define RCBL_STRETCH_CYC 12'h960
`define RCBL_BOOT_LEAD_CYC 12'h004
`define RCBL_SAMPLE_CYC 12'h010

`endif

// ==== core/rcbl_pkg.sv ====
// Types of the reset controller with boot latch
package rcbl_pkg;

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_ASSERT = 6'h02,
        ST_STRETCH = 6'h04,
        ST_RELEASE = 6'h08,
        ST_EXTHOLD = 6'h10,
        ST_BOOT = 6'h20
    } rcbl_state_t;

    typedef struct packed {
        rcbl_state_t st;
        logic [11:0] cnt;
        logic [7:0] cause;
        logic bootSel;
        logic swReq;
        logic lockEn;
        logic clkSelRc;
        logic chipRst;
        logic pinOe;
        logic pinOut;
        logic [31:0] rdData;
    } rcbl_regs_t;

endpackage : rcbl_pkg

// ==== core/rcbl_reset_ctrl.sv ====
// Reset controller: source collection, pin stretch, pin sample, boot latch
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "rcbl_params.svh"

module rcbl_reset_ctrl
#(
    parameter logic [11:0] SAMPLE_CYC = `RCBL_SAMPLE_CYC
)
(
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Internal reset sources
    input wire logic lowVoltReq,
    input wire logic lockLoss,
    input wire logic clockLoss,
    input wire logic watchdogReq,
    input wire logic checkstop0,
    input wire logic checkstop1,
    input wire logic jtagReq,
    input wire logic jtagPinAssert,
    // Reset pin, open drain, active low
    input wire logic rstPinIn,
    output logic rstPinOut,
    output logic rstPinOe,
    // Boot-select pad
    input wire logic bootSelectPad,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Chip-level results
    output logic chipRst,
    output logic clkSelRc,
    output logic bootSelect
);
    import rcbl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rcbl_regs_t blk_reg;
    rcbl_regs_t blk_next;
    logic [7:0] srcVec;
    logic anySrc;

    // ------------------------------------------------------------
    // Source collection
    // ------------------------------------------------------------
    always_comb
    begin
        srcVec = 8'h00;
        srcVec[`RCBL_CAUSE_LVI] = lowVoltReq;
        srcVec[`RCBL_CAUSE_LOL] = lockLoss & blk_reg.lockEn;
        srcVec[`RCBL_CAUSE_LOC] = clockLoss;
        srcVec[`RCBL_CAUSE_WDT] = watchdogReq;
        srcVec[`RCBL_CAUSE_CHK] = checkstop0 | checkstop1;
        srcVec[`RCBL_CAUSE_SW] = blk_reg.swReq;
        anySrc = |srcVec;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        blk_next = blk_reg;
        blk_next.rdData = 32'h0000_0000;
        blk_next.swReq = 1'h0;
        blk_next.pinOut = 1'h0;

        // Register writes
        if (regWr && regAddr == `RCBL_OFS_CTRL)
        begin
            blk_next.swReq = regWrData[`RCBL_CTRL_SW];
            blk_next.lockEn = regWrData[`RCBL_CTRL_LOLE];
            blk_next.clkSelRc = regWrData[`RCBL_CTRL_CLKRC];
        end

        // Register reads, answered in the next cycle
        if (regRd)
        begin
            if (regAddr == `RCBL_OFS_CAUSE)
            begin
                blk_next.rdData[7:0] = blk_reg.cause;
                blk_next.rdData[`RCBL_CAUSE_BOOT] = blk_reg.bootSel;
            end
            else if (regAddr == `RCBL_OFS_CTRL)
            begin
                blk_next.rdData[`RCBL_CTRL_SW] = blk_reg.swReq;
                blk_next.rdData[`RCBL_CTRL_LOLE] = blk_reg.lockEn;
                blk_next.rdData[`RCBL_CTRL_CLKRC] = blk_reg.clkSelRc;
            end
        end

        unique case (blk_reg.st)
            ST_RUN:
            begin
                // Pin pulled low from outside while running
                if (!rstPinIn)
                begin
                    blk_next.st = ST_EXTHOLD;
                    blk_next.chipRst = 1'h1;
                    blk_next.cause = `RCBL_CAUSE_EXTONLY;
                end
            end
            ST_ASSERT:
            begin
                blk_next.chipRst = 1'h1;
                blk_next.pinOe = anySrc | (jtagReq & jtagPinAssert);
                blk_next.cause = blk_reg.cause | srcVec;
                if (!anySrc && !jtagReq)
                begin
                    blk_next.st = ST_STRETCH;
                    blk_next.pinOe = 1'h1;
                    blk_next.cnt = `RCBL_STRETCH_CYC - 12'h001;
                end
            end
            ST_STRETCH:
            begin
                blk_next.pinOe = 1'h1;
                if (blk_reg.cnt == 12'h000)
                begin
                    blk_next.st = ST_RELEASE;
                    blk_next.pinOe = 1'h0;
                    blk_next.cnt = SAMPLE_CYC - 12'h001;
                end
                else
                begin
                    blk_next.cnt = blk_reg.cnt - 12'h001;
                end
            end
            ST_RELEASE:
            begin
                if (blk_reg.cnt != 12'h000)
                begin
                    blk_next.cnt = blk_reg.cnt - 12'h001;
                end
                else if (!rstPinIn)
                begin
                    // Pin still low: someone outside wants reset
                    blk_next.st = ST_EXTHOLD;
                    blk_next.cause = `RCBL_CAUSE_EXTONLY;
                end
                else
                begin
                    blk_next.st = ST_BOOT;
                    blk_next.bootSel = bootSelectPad;
                    blk_next.cnt = `RCBL_BOOT_LEAD_CYC - 12'h001;
                end
            end
            ST_EXTHOLD:
            begin
                // Held in reset for as long as the pin is low
                if (rstPinIn)
                begin
                    blk_next.st = ST_BOOT;
                    blk_next.bootSel = bootSelectPad;
                    blk_next.cnt = `RCBL_BOOT_LEAD_CYC - 12'h001;
                end
            end
            ST_BOOT:
            begin
                if (blk_reg.cnt == 12'h000)
                begin
                    blk_next.st = ST_RUN;
                    blk_next.chipRst = 1'h0;
                end
                else
                begin
                    blk_next.cnt = blk_reg.cnt - 12'h001;
                end
            end
        endcase

        // Any internal source (lock loss only with lockEn set) restarts the sequence from any state except ST_ASSERT
        if ((anySrc || jtagReq) && blk_reg.st != ST_ASSERT)
        begin
            blk_next.st = ST_ASSERT;
            blk_next.chipRst = 1'h1;
            blk_next.pinOe = anySrc | (jtagReq & jtagPinAssert);
            if (anySrc)
            begin
                blk_next.cause = srcVec;
            end
        end

        // Reset always falls back to the RC oscillator
        if (blk_next.chipRst)
        begin
            blk_next.clkSelRc = 1'h1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            blk_reg.st <= ST_ASSERT;
            blk_reg.cnt <= 12'h000;
            blk_reg.cause <= `RCBL_CAUSE_RST;
            blk_reg.bootSel <= `RCBL_BOOT_FLASH;
            blk_reg.swReq <= 1'h0;
            blk_reg.lockEn <= 1'h0;
            blk_reg.clkSelRc <= 1'h1;
            blk_reg.chipRst <= 1'h1;
            blk_reg.pinOe <= 1'h1;
            blk_reg.pinOut <= 1'h0;
            blk_reg.rdData <= 32'h0000_0000;
        end
        else
        begin
            blk_reg <= blk_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rstPinOut = blk_reg.pinOut;
    assign rstPinOe = blk_reg.pinOe;
    assign regRdData = blk_reg.rdData;
    assign chipRst = blk_reg.chipRst;
    assign clkSelRc = blk_reg.clkSelRc;
    assign bootSelect = blk_reg.bootSel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [11:0] stretchLen;
    logic bootEntry;
    logic quietIn;

    assign bootEntry = blk_reg.st == ST_BOOT && blk_reg.cnt == 12'h003;
    assign quietIn = !anySrc && !jtagReq;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stretchLen <= 12'h000;
        end
        else if (blk_reg.st == ST_STRETCH)
        begin
            stretchLen <= stretchLen + 12'h001;
        end
        else
        begin
            stretchLen <= 12'h000;
        end
    end

    sequence s_runQuiet;
        blk_reg.st == ST_RUN && quietIn;
    endsequence

    sequence s_swWrite;
        regWr && regAddr == `RCBL_OFS_CTRL && regWrData[`RCBL_CTRL_SW];
    endsequence

    sequence s_releaseLow;
        blk_reg.st == ST_RELEASE && blk_reg.cnt == 12'h000 && !rstPinIn;
    endsequence

    property p_bootLead;
        @(posedge mclk) disable iff (sys_rst)
        $fell(blk_reg.chipRst) |-> $past(bootEntry, 4);
    endproperty

    property p_stretchLen;
        @(posedge mclk) disable iff (sys_rst)
        (blk_reg.st == ST_STRETCH && blk_next.st == ST_RELEASE)
            |-> stretchLen == `RCBL_STRETCH_CYC - 12'h001;
    endproperty

    a_boot_lead: assert property (p_bootLead)
        else $error("chip reset did not fall four clocks after boot latch");

    a_stretch_len: assert property (p_stretchLen)
        else $error("pin stretch length wrong");

    a_stretch_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        blk_reg.st == ST_STRETCH |-> rstPinOe && chipRst)
        else $error("pin released during stretch");

    a_ext_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        s_runQuiet ##0 !rstPinIn |=> chipRst && blk_reg.cause == `RCBL_CAUSE_EXTONLY)
        else $error("external reset cause not recorded");

    a_src_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        anySrc |=> rstPinOe && chipRst)
        else $error("pin not driven for active source");

    a_jtag_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        blk_reg.st == ST_RUN && jtagReq && !anySrc
            |=> chipRst && $stable(blk_reg.cause) && rstPinOe == $past(jtagPinAssert))
        else $error("jtag reset altered cause flags");

    a_lol_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        s_runQuiet ##0 rstPinIn && !blk_reg.lockEn && lockLoss |=> !chipRst)
        else $error("lock loss reset without enable");

    a_sw_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        s_runQuiet ##0 rstPinIn ##0 s_swWrite ##1 (quietIn || blk_reg.swReq)
            |=> chipRst && rstPinOe && blk_reg.cause[`RCBL_CAUSE_SW])
        else $error("software reset not taken");

    a_sample_low: assert property (@(posedge mclk) disable iff (sys_rst)
        s_releaseLow ##0 quietIn |=> blk_reg.st == ST_EXTHOLD && chipRst)
        else $error("low pin at sample not treated as request");

    a_boot_latch: assert property (@(posedge mclk) disable iff (sys_rst)
        bootEntry |-> bootSelect == $past(bootSelectPad))
        else $error("boot select not latched from pad");

    a_clk_rc: assert property (@(posedge mclk) disable iff (sys_rst)
        chipRst |-> clkSelRc)
        else $error("clock not on RC oscillator during reset");

    a_run_release: assert property (@(posedge mclk) disable iff (sys_rst)
        blk_reg.st == ST_RUN |-> !rstPinOe && !rstPinOut)
        else $error("reset pin driven while running");

    a_ext_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        blk_reg.st == ST_EXTHOLD && !rstPinIn |=> chipRst && blk_reg.st != ST_RUN)
        else $error("chip left reset while pin held low");

    a_stretch_end: assert property (@(posedge mclk) disable iff (sys_rst)
        blk_reg.st == ST_STRETCH && blk_reg.cnt == 12'h000 && quietIn |=> !rstPinOe)
        else $error("pin not released after stretch");

    a_sample_high: assert property (@(posedge mclk) disable iff (sys_rst)
        blk_reg.st == ST_RELEASE && blk_reg.cnt == 12'h000 && rstPinIn && quietIn
            |=> bootEntry && chipRst)
        else $error("boot latch not started on high pin");

    a_jtag_pin: assert property (@(posedge mclk) disable iff (sys_rst)
        blk_reg.st == ST_ASSERT && jtagReq && !anySrc |=> rstPinOe == $past(jtagPinAssert))
        else $error("reset pin does not follow jtag instruction");

endmodule : rcbl_reset_ctrl

// ==== tb/rcbl_board_model.sv ====
// Board side: reset pin pull-up, external reset button, boot strap
`timescale 1ns/10ps

module rcbl_board_model
(
    // Device side of the reset pin
    input wire logic rstPinOe,
    input wire logic rstPinOut,
    // Board controls
    input wire logic extHold,
    input wire logic bootLevel,
    // Resolved levels
    output logic rstPinIn,
    output logic bootSelectPad
);
    // Open drain with pull-up: low while either party pulls
    assign rstPinIn = ((rstPinOe && !rstPinOut) || extHold) ? 1'b0 : 1'b1;
    // Strap is a static board level
    assign bootSelectPad = bootLevel;
endmodule : rcbl_board_model

// ==== tb/tb.sv ====
// Testbench of the reset controller with boot latch
`timescale 1ns/10ps
`include "rcbl_params.svh"

module tb;
    import rcbl_pkg::*;
    localparam int LIM = 6000;
    logic mclk, sys_rst, extHold, bootLevel, jtagPinAssert, regWr, regRd;
    logic [6:0] src;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, rd;
    logic rstPinIn, rstPinOut, rstPinOe, bootSelectPad, chipRst, clkSelRc, bootSelect;
    int num_errors, samples_checked, n;
    int srcIdx [5] = '{0, 2, 3, 4, 5};
    int causeBit [5] = '{1, 4, 5, 6, 6};

    rcbl_reset_ctrl #(.SAMPLE_CYC(12'h002)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .lowVoltReq(src[0]), .lockLoss(src[1]), .clockLoss(src[2]), .watchdogReq(src[3]),
        .checkstop0(src[4]), .checkstop1(src[5]), .jtagReq(src[6]),
        .jtagPinAssert(jtagPinAssert), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut),
        .rstPinOe(rstPinOe), .bootSelectPad(bootSelectPad), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .chipRst(chipRst), .clkSelRc(clkSelRc), .bootSelect(bootSelect));

    rcbl_board_model board (.rstPinOe(rstPinOe), .rstPinOut(rstPinOut), .extHold(extHold),
        .bootLevel(bootLevel), .rstPinIn(rstPinIn), .bootSelectPad(bootSelectPad));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // Common tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task test_done();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task tick();
        @(posedge mclk);
        #1;
        n++;
        if (n > LIM)
        begin
            num_errors++;
            $display("ERROR at %0t: wait limit reached", $time);
            test_done();
        end
    endtask : tick

    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        rd = regRdData;
    endtask : reg_rd

    // Counts edges with the pin still driven after the sources drop
    task count_stretch();
        n = 0;
        tick();
        check(chipRst, 1'b1);
        check(clkSelRc, 1'b1);
        check(rstPinOut, 1'b0);
        while (rstPinOe === 1'b1)
            tick();
        check(n - 1, 2400);
    endtask : count_stretch

    // Waits for the boot latch, times chip reset release, reads the cause
    task complete(input logic [7:0] flags);
        n = 0;
        while (bootSelect !== bootLevel)
            tick();
        n = 0;
        while (chipRst === 1'b1)
            tick();
        check(n, 4);
        reg_rd(`RCBL_OFS_CAUSE);
        check(rd, {15'h0, bootLevel, 8'h00, flags});
    endtask : complete

    task pulse(input int idx);
        @(posedge mclk);
        bootLevel <= ~bootLevel;
        src[idx] <= 1'b1;
        repeat (3) @(posedge mclk);
        src[idx] <= 1'b0;
        count_stretch();
    endtask : pulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_sources();
        for (int i = 0; i < 5; i++)
        begin
            pulse(srcIdx[i]);
            complete(8'h01 << causeBit[i]);
        end
        $display("internal sources done");
    endtask : t_sources

    task t_lock();
        @(posedge mclk);
        src[1] <= 1'b1;
        repeat (20) tick();
        check(chipRst, 1'b0);
        @(posedge mclk);
        src[1] <= 1'b0;
        reg_wr(`RCBL_OFS_CTRL, 32'h00000002);
        reg_rd(`RCBL_OFS_CTRL);
        check(rd[1], 1'b1);
        pulse(1);
        complete(8'h08);
        $display("lock loss done");
    endtask : t_lock

    task t_jtag();
        @(posedge mclk);
        bootLevel <= ~bootLevel;
        src[6] <= 1'b1;
        repeat (3) tick();
        check(chipRst, 1'b1);
        check(rstPinOe, 1'b0);
        @(posedge mclk);
        jtagPinAssert <= 1'b1;
        repeat (2) tick();
        check(rstPinOe, 1'b1);
        check(chipRst, 1'b1);
        @(posedge mclk);
        src[6] <= 1'b0;
        jtagPinAssert <= 1'b0;
        count_stretch();
        complete(8'h08);
        $display("jtag done");
    endtask : t_jtag

    task t_soft();
        @(posedge mclk);
        bootLevel <= ~bootLevel;
        reg_wr(`RCBL_OFS_CTRL, 32'h00000001);
        tick();
        check(chipRst, 1'b1);
        check(rstPinOe, 1'b1);
        complete(8'h80);
        reg_wr(`RCBL_OFS_CAUSE, 32'hFFFFFFFF);
        reg_rd(`RCBL_OFS_CAUSE);
        check(rd, {15'h0, bootLevel, 8'h00, 8'h80});
        reg_rd(8'h10);
        check(rd, 32'h00000000);
        $display("software reset done");
    endtask : t_soft

    task t_ext();
        @(posedge mclk);
        bootLevel <= ~bootLevel;
        extHold <= 1'b1;
        repeat (2) tick();
        check(chipRst, 1'b1);
        repeat (50) tick();
        check(chipRst, 1'b1);
        @(posedge mclk);
        extHold <= 1'b0;
        complete(8'h04);
        @(posedge mclk);
        extHold <= 1'b1;
        pulse(3);
        repeat (40) tick();
        check(chipRst, 1'b1);
        @(posedge mclk);
        extHold <= 1'b0;
        complete(8'h04);
        $display("external reset done");
    endtask : t_ext

    initial
    begin
        sys_rst = 1'b1;
        src = 7'h00;
        extHold = 1'b0;
        bootLevel = 1'b1;
        jtagPinAssert = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h00000000;
        num_errors = 0;
        samples_checked = 0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        complete(8'h01);
        $display("power-on done");
        t_sources();
        t_lock();
        t_jtag();
        t_soft();
        t_ext();
        test_done();
    end
endmodule : tb
